// file: rtl/cmx_pkg.sv
`default_nettype none

package cmx_pkg;

  // ****************************************
  // opcodes
  // ****************************************
  localparam logic [15:0] OP_CMP_FIRST_ACC_VIA_DATA_ONE = 16'h83d6;
  localparam logic [15:0] OP_CMP_SECOND_ACC_VIA_DATA_ONE = 16'h8bd6;
  localparam logic [15:0] OP_CMP_FIRST_ACC_VIA_DATA_TWO = 16'h83d3;
  localparam logic [15:0] OP_CMP_SECOND_ACC_VIA_DATA_TWO = 16'h8bd3;
  localparam logic [15:0] OP_MOVE_WORDS_EXEC_TO_EXEC = 16'h8bd7;
  localparam logic [15:0] OP_MOVE_WORDS_EXEC_TO_DATA_ONE = 16'h8bd8;
  localparam logic [15:0] OP_MOVE_WORDS_EXEC_TO_DATA_TWO = 16'h8bd9;
  localparam logic [15:0] OP_MOVE_WORDS_DATA_ONE_TO_EXEC = 16'h8bda;
  localparam logic [15:0] OP_MOVE_WORDS_DATA_ONE_TO_DATA_ONE = 16'h8bdb;

  // ****************************************
  // counts, widths and steps
  // ****************************************
  localparam int WORD_W = 16;
  localparam int FIFO_DEPTH = 8;
  localparam logic [1:0] IND_LEVELS = 2'h3;
  localparam logic [15:0] PC_STEP_NOSKIP = 16'h0002;
  localparam logic [15:0] PC_STEP_SKIP = 16'h0003;
  localparam logic [15:0] PC_STEP_MOVE = 16'h0001;
  localparam logic [15:0] ADDR_STEP = 16'h0001;
  localparam int ADDR_MSB = 15;

  typedef enum logic [1:0] {
    MAP_EXEC = 2'b00,
    MAP_FIRST_DATA = 2'b01,
    MAP_SECOND_DATA = 2'b10
  } cmx_map_e;

  typedef enum logic [1:0] {
    MOP_READ = 2'b00,
    MOP_WRITE = 2'b01,
    MOP_CHECK = 2'b10
  } cmx_mop_e;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_PTR = 3'b001,
    ST_RES = 3'b010,
    ST_IND = 3'b011,
    ST_OPND = 3'b100,
    ST_CHK_SRC = 3'b101,
    ST_CHK_DST = 3'b110,
    ST_MOVE = 3'b111
  } cmx_state_e;

  // ****************************************
  // carriers
  // ****************************************
  typedef struct packed {
    logic valid;
    cmx_mop_e op;
    cmx_map_e map;
    logic [15:0] addr;
    logic [15:0] wdata;
    logic accMem;
    logic baseChk;
  } cmx_memReq_s;

  typedef struct packed {
    logic ack;
    logic [15:0] rdata;
    logic fault;
  } cmx_memRsp_s;

  typedef struct packed {
    logic start;
    logic [15:0] opcode;
    logic [15:0] pc;
    logic [15:0] accA;
    logic [15:0] accB;
    logic [15:0] idx;
    logic cdsMode;
  } cmx_cmd_s;

  typedef struct packed {
    logic done;
    logic skip;
    logic restart;
    logic fault;
    logic [15:0] pc;
    logic [15:0] accA;
    logic [15:0] accB;
    logic [15:0] idx;
  } cmx_res_s;

  typedef struct packed {
    cmx_state_e st;
    logic busy;
    cmx_cmd_s cmd;
    logic [15:0] ptr;
    logic [1:0] lvl;
    logic [15:0] pend;
    logic stop;
    cmx_memReq_s req;
    cmx_res_s res;
  } cmx_top_s;

endpackage

`default_nettype wire

// file: rtl/cmx_exec.sv
`timescale 1ns/1ps
`default_nettype none

// ****************************************
// word fifo between source reads and writes
// ****************************************
module cmx_fifo #(
  parameter int W = 16,
  parameter int D = 8
) (
  input wire logic clk_sys, // system clock
  input wire logic nrst, // async reset, low
  input wire logic inValid, // push request
  output logic inReady, // room for a word
  input wire logic [W-1:0] inData, // pushed word
  output logic outValid, // word available
  input wire logic outReady, // pop request
  output logic [W-1:0] outData // head word
);
  localparam int AW = (D > 1) ? $clog2(D) : 1;
  localparam int CW = $clog2(D + 1);

  typedef struct packed {
    logic [D-1:0][W-1:0] mem;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [CW-1:0] cnt;
  } cmx_fifoSt_s;

  cmx_fifoSt_s s_ff;
  cmx_fifoSt_s nxt_s;
  logic doPush;
  logic doPop;

  // pointer wrap also holds for depths that are not powers of two
  function automatic logic [AW-1:0] ptrInc(input logic [AW-1:0] p);
    ptrInc = (p == AW'(D - 1)) ? '0 : p + 1'b1;
  endfunction

  // flags straight from the count
  assign inReady = (s_ff.cnt != CW'(D));
  assign outValid = (s_ff.cnt != '0);
  assign outData = s_ff.mem[s_ff.rp];
  assign doPush = inValid && inReady;
  assign doPop = outValid && outReady;

  // next state
  always_comb begin
    nxt_s = s_ff;
    if (doPush) begin
      nxt_s.mem[s_ff.wp] = inData;
      nxt_s.wp = ptrInc(s_ff.wp);
    end
    if (doPop) begin
      nxt_s.rp = ptrInc(s_ff.rp);
    end
    if (doPush && !doPop) begin
      nxt_s.cnt = s_ff.cnt + 1'b1;
    end else if (doPop && !doPush) begin
      nxt_s.cnt = s_ff.cnt - 1'b1;
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      s_ff <= '0;
    end else begin
      s_ff <= nxt_s;
    end
  end
endmodule

// ****************************************
// cross-map compare and word move engine
// ****************************************
module cmx_exec (
  input wire logic clk_sys, // system clock
  input wire logic nrst, // async reset, low
  input wire cmx_pkg::cmx_cmd_s cmd, // instruction start and regs
  input wire logic irqPend, // interrupt waiting
  output cmx_pkg::cmx_memReq_s memReq, // memory request
  input wire cmx_pkg::cmx_memRsp_s memRsp, // memory answer
  output cmx_pkg::cmx_res_s res, // result and new regs
  output logic busy // instruction running
);
  cmx_pkg::cmx_top_s s_ff;
  cmx_pkg::cmx_top_s nxt_s;
  logic fifoInRdy;
  logic fifoOutVld;
  logic [15:0] fifoOutData;
  logic fifoPush;
  logic fifoPop;
  logic fin;
  logic canRead;
  logic [15:0] selAcc;

  // ****************************************
  // opcode decode
  // ****************************************
  function automatic logic isCmp(input logic [15:0] op);
    isCmp = (op == cmx_pkg::OP_CMP_FIRST_ACC_VIA_DATA_ONE)
         || (op == cmx_pkg::OP_CMP_SECOND_ACC_VIA_DATA_ONE)
         || (op == cmx_pkg::OP_CMP_FIRST_ACC_VIA_DATA_TWO)
         || (op == cmx_pkg::OP_CMP_SECOND_ACC_VIA_DATA_TWO);
  endfunction

  function automatic logic isMove(input logic [15:0] op);
    isMove = (op == cmx_pkg::OP_MOVE_WORDS_EXEC_TO_EXEC)
          || (op == cmx_pkg::OP_MOVE_WORDS_EXEC_TO_DATA_ONE)
          || (op == cmx_pkg::OP_MOVE_WORDS_EXEC_TO_DATA_TWO)
          || (op == cmx_pkg::OP_MOVE_WORDS_DATA_ONE_TO_EXEC)
          || (op == cmx_pkg::OP_MOVE_WORDS_DATA_ONE_TO_DATA_ONE);
  endfunction

  // compares: the low opcode bits pick the data map
  function automatic cmx_pkg::cmx_map_e cmpMap(input logic [15:0] op);
    cmpMap = (op[2:0] == 3'h6) ? cmx_pkg::MAP_FIRST_DATA : cmx_pkg::MAP_SECOND_DATA;
  endfunction

  function automatic cmx_pkg::cmx_map_e srcMap(input logic [15:0] op);
    if (op == cmx_pkg::OP_MOVE_WORDS_DATA_ONE_TO_EXEC
        || op == cmx_pkg::OP_MOVE_WORDS_DATA_ONE_TO_DATA_ONE) begin
      srcMap = cmx_pkg::MAP_FIRST_DATA;
    end else begin
      srcMap = cmx_pkg::MAP_EXEC;
    end
  endfunction

  function automatic cmx_pkg::cmx_map_e dstMap(input logic [15:0] op);
    case (op)
      cmx_pkg::OP_MOVE_WORDS_EXEC_TO_DATA_ONE: dstMap = cmx_pkg::MAP_FIRST_DATA;
      cmx_pkg::OP_MOVE_WORDS_DATA_ONE_TO_DATA_ONE: dstMap = cmx_pkg::MAP_FIRST_DATA;
      cmx_pkg::OP_MOVE_WORDS_EXEC_TO_DATA_TWO: dstMap = cmx_pkg::MAP_SECOND_DATA;
      default: dstMap = cmx_pkg::MAP_EXEC;
    endcase
  endfunction

  // base checks happen only where the address lives in the execute map
  function automatic logic chkSrc(input logic [15:0] op);
    chkSrc = isMove(op) && (srcMap(op) == cmx_pkg::MAP_EXEC);
  endfunction

  function automatic logic chkDst(input logic [15:0] op);
    chkDst = isMove(op) && (dstMap(op) == cmx_pkg::MAP_EXEC);
  endfunction

  function automatic cmx_pkg::cmx_memReq_s mkReq(
    input cmx_pkg::cmx_mop_e op,
    input cmx_pkg::cmx_map_e map,
    input logic [15:0] addr,
    input logic [15:0] wdata,
    input logic accMem,
    input logic baseChk
  );
    mkReq.valid = 1'b1;
    mkReq.op = op;
    mkReq.map = map;
    mkReq.addr = addr;
    mkReq.wdata = wdata;
    mkReq.accMem = accMem;
    mkReq.baseChk = baseChk;
  endfunction

  // the buffer holds words read but not yet written back
  cmx_fifo #(
    .W(cmx_pkg::WORD_W),
    .D(cmx_pkg::FIFO_DEPTH)
  ) u_fifo (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .inValid(fifoPush),
    .inReady(fifoInRdy),
    .inData(memRsp.rdata),
    .outValid(fifoOutVld),
    .outReady(fifoPop),
    .outData(fifoOutData)
  );

  assign selAcc = s_ff.cmd.opcode[11] ? s_ff.cmd.accB : s_ff.cmd.accA;
  // a full buffer or a pending interrupt stalls the reads
  assign canRead = !s_ff.stop && !irqPend && fifoInRdy
                && (s_ff.cmd.idx > s_ff.pend);

  // ****************************************
  // sequencer
  // ****************************************
  always_comb begin
    nxt_s = s_ff;
    nxt_s.res.done = 1'b0;
    fin = 1'b0;
    fifoPush = 1'b0;
    fifoPop = 1'b0;
    if (memRsp.ack) begin
      nxt_s.req.valid = 1'b0;
    end
    case (s_ff.st)
      cmx_pkg::ST_IDLE: begin
        if (cmd.start) begin
          nxt_s.cmd = cmd;
          nxt_s.busy = 1'b1;
          nxt_s.lvl = '0;
          nxt_s.pend = '0;
          nxt_s.stop = 1'b0;
          nxt_s.res.skip = 1'b0;
          nxt_s.res.restart = 1'b0;
          nxt_s.res.fault = 1'b0;
          if (isCmp(cmd.opcode)) begin
            nxt_s.req = mkReq(cmx_pkg::MOP_READ, cmx_pkg::MAP_EXEC,
                              cmd.pc + cmx_pkg::ADDR_STEP, '0, 1'b1, 1'b0);
            nxt_s.st = cmx_pkg::ST_PTR;
          end else if (cmd.cdsMode && chkSrc(cmd.opcode)) begin
            nxt_s.req = mkReq(cmx_pkg::MOP_CHECK, cmx_pkg::MAP_EXEC,
                              cmd.accA, '0, 1'b0, 1'b1);
            nxt_s.st = cmx_pkg::ST_CHK_SRC;
          end else if (cmd.cdsMode && chkDst(cmd.opcode)) begin
            nxt_s.req = mkReq(cmx_pkg::MOP_CHECK, cmx_pkg::MAP_EXEC,
                              cmd.accB, '0, 1'b0, 1'b1);
            nxt_s.st = cmx_pkg::ST_CHK_DST;
          end else if (isMove(cmd.opcode)) begin
            nxt_s.st = cmx_pkg::ST_MOVE;
          end else begin
            // foreign opcode: hand it straight back as a fault
            nxt_s.res.fault = 1'b1;
            fin = 1'b1;
          end
        end
      end
      cmx_pkg::ST_PTR, cmx_pkg::ST_IND: begin
        if (memRsp.ack) begin
          nxt_s.ptr = memRsp.rdata;
          nxt_s.res.fault = memRsp.fault;
          fin = memRsp.fault;
          nxt_s.st = cmx_pkg::ST_RES;
        end
      end
      cmx_pkg::ST_RES: begin
        if (s_ff.ptr[cmx_pkg::ADDR_MSB]) begin
          if (s_ff.lvl == cmx_pkg::IND_LEVELS && irqPend) begin
            nxt_s.res.restart = 1'b1;
            fin = 1'b1;
          end else begin
            // indirect step in the execute map, accumulators reachable
            nxt_s.req = mkReq(cmx_pkg::MOP_READ, cmx_pkg::MAP_EXEC,
                              {1'b0, s_ff.ptr[14:0]}, '0, 1'b1,
                              s_ff.cmd.cdsMode);
            if (s_ff.lvl != cmx_pkg::IND_LEVELS) begin
              nxt_s.lvl = s_ff.lvl + 1'b1;
            end
            nxt_s.st = cmx_pkg::ST_IND;
          end
        end else begin
          // low addresses land on real memory words here
          nxt_s.req = mkReq(cmx_pkg::MOP_READ, cmpMap(s_ff.cmd.opcode),
                            {1'b0, s_ff.ptr[14:0]}, '0, 1'b0, 1'b0);
          nxt_s.st = cmx_pkg::ST_OPND;
        end
      end
      cmx_pkg::ST_OPND: begin
        if (memRsp.ack) begin
          fin = 1'b1;
          nxt_s.res.fault = memRsp.fault;
          if (!memRsp.fault) begin
            nxt_s.res.skip = (memRsp.rdata != selAcc);
            nxt_s.cmd.pc = s_ff.cmd.pc + ((memRsp.rdata != selAcc) ?
                           cmx_pkg::PC_STEP_SKIP : cmx_pkg::PC_STEP_NOSKIP);
          end
        end
      end
      cmx_pkg::ST_CHK_SRC: begin
        if (memRsp.ack) begin
          nxt_s.cmd.accA = memRsp.rdata; // base-relative form
          if (memRsp.fault) begin
            nxt_s.res.fault = 1'b1;
            fin = 1'b1;
          end else if (chkDst(s_ff.cmd.opcode)) begin
            nxt_s.req = mkReq(cmx_pkg::MOP_CHECK, cmx_pkg::MAP_EXEC,
                              s_ff.cmd.accB, '0, 1'b0, 1'b1);
            nxt_s.st = cmx_pkg::ST_CHK_DST;
          end else begin
            nxt_s.st = cmx_pkg::ST_MOVE;
          end
        end
      end
      cmx_pkg::ST_CHK_DST: begin
        if (memRsp.ack) begin
          nxt_s.cmd.accB = memRsp.rdata;
          nxt_s.res.fault = memRsp.fault;
          fin = memRsp.fault;
          nxt_s.st = cmx_pkg::ST_MOVE;
        end
      end
      cmx_pkg::ST_MOVE: begin
        if (s_ff.req.valid) begin
          if (memRsp.ack && s_ff.req.op == cmx_pkg::MOP_READ) begin
            fifoPush = 1'b1;
            nxt_s.cmd.accA = s_ff.cmd.accA + cmx_pkg::ADDR_STEP;
            nxt_s.pend = s_ff.pend + cmx_pkg::ADDR_STEP;
          end else if (memRsp.ack) begin
            // progress lives in the registers word by word
            nxt_s.cmd.accB = s_ff.cmd.accB + cmx_pkg::ADDR_STEP;
            nxt_s.cmd.idx = s_ff.cmd.idx - cmx_pkg::ADDR_STEP;
          end
        end else begin
          nxt_s.stop = s_ff.stop || irqPend;
          if (canRead) begin
            nxt_s.req = mkReq(cmx_pkg::MOP_READ, srcMap(s_ff.cmd.opcode),
                              s_ff.cmd.accA, '0, 1'b0, 1'b0);
          end else if (fifoOutVld) begin
            fifoPop = 1'b1;
            nxt_s.pend = s_ff.pend - cmx_pkg::ADDR_STEP;
            nxt_s.req = mkReq(cmx_pkg::MOP_WRITE, dstMap(s_ff.cmd.opcode),
                              s_ff.cmd.accB, fifoOutData, 1'b0,
                              1'b0);
          end else begin
            // buffer drained: either finished or parked for the interrupt
            nxt_s.res.restart = (s_ff.cmd.idx != '0);
            if (s_ff.cmd.idx == '0) begin
              nxt_s.cmd.pc = s_ff.cmd.pc + cmx_pkg::PC_STEP_MOVE;
            end
            fin = 1'b1;
          end
        end
      end
      default: begin
        nxt_s.st = cmx_pkg::ST_IDLE;
      end
    endcase
    if (fin) begin
      nxt_s.st = cmx_pkg::ST_IDLE;
      nxt_s.busy = 1'b0;
      nxt_s.res.done = 1'b1;
      nxt_s.res.pc = nxt_s.cmd.pc;
      nxt_s.res.accA = nxt_s.cmd.accA;
      nxt_s.res.accB = nxt_s.cmd.accB;
      nxt_s.res.idx = nxt_s.cmd.idx;
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      s_ff <= '0;
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign memReq = s_ff.req;
  assign res = s_ff.res;
  assign busy = s_ff.busy;

  // ****************************************
  // checks
  // ****************************************
  a_ptr_fetch: assert property (@(posedge clk_sys) disable iff (!nrst)
    (s_ff.st == cmx_pkg::ST_IDLE && cmd.start && isCmp(cmd.opcode))
    |=> (memReq.valid && memReq.addr == $past(cmd.pc) + 16'h0001))
    else $error("pointer word not fetched at pc plus one");

  a_cmp_skip: assert property (@(posedge clk_sys) disable iff (!nrst)
    (s_ff.st == cmx_pkg::ST_OPND && memRsp.ack && !memRsp.fault)
    |=> (res.done && res.skip == ($past(memRsp.rdata) != $past(selAcc))))
    else $error("skip does not follow inequality");

  a_skip_pc: assert property (@(posedge clk_sys) disable iff (!nrst)
    (s_ff.st == cmx_pkg::ST_OPND && memRsp.ack && !memRsp.fault)
    |=> (res.pc == $past(s_ff.cmd.pc) + (res.skip ? 16'h0003 : 16'h0002)))
    else $error("pc step after compare wrong");

  a_final_map: assert property (@(posedge clk_sys) disable iff (!nrst)
    (s_ff.st == cmx_pkg::ST_OPND && memReq.valid)
    |-> (memReq.map == cmpMap(s_ff.cmd.opcode) && !memReq.accMem && !memReq.baseChk))
    else $error("final operand access uses wrong map or checks");

  a_ind_exec: assert property (@(posedge clk_sys) disable iff (!nrst)
    (s_ff.st == cmx_pkg::ST_IND && memReq.valid)
    |-> (memReq.map == cmx_pkg::MAP_EXEC && memReq.accMem
         && memReq.baseChk == s_ff.cmd.cdsMode))
    else $error("indirect step not in execute map");

  a_ind_restart: assert property (@(posedge clk_sys) disable iff (!nrst)
    (s_ff.st == cmx_pkg::ST_RES && s_ff.ptr[15] && irqPend)
    |=> (res.done == ($past(s_ff.lvl) == cmx_pkg::IND_LEVELS) && res.restart == res.done))
    else $error("interrupt taken at wrong indirection depth");

  a_move_exit: assert property (@(posedge clk_sys) disable iff (!nrst)
    (res.done && isMove(s_ff.cmd.opcode) && !res.restart && !res.fault)
    |-> (res.idx == 16'h0000 && !fifoOutVld && s_ff.pend == 16'h0000))
    else $error("move exit with words left over");

  a_move_write: assert property (@(posedge clk_sys) disable iff (!nrst)
    (s_ff.st == cmx_pkg::ST_MOVE && memReq.valid && memReq.op == cmx_pkg::MOP_WRITE)
    |-> (memReq.map == dstMap(s_ff.cmd.opcode) && memReq.addr == s_ff.cmd.accB))
    else $error("move write to wrong map or address");

  a_chk_first: assert property (@(posedge clk_sys) disable iff (!nrst)
    (s_ff.st == cmx_pkg::ST_IDLE && cmd.start && cmd.cdsMode && chkSrc(cmd.opcode))
    |=> (memReq.op == cmx_pkg::MOP_CHECK && memReq.addr == $past(cmd.accA)))
    else $error("source not checked before move");

  a_move_progress: assert property (@(posedge clk_sys) disable iff (!nrst)
    (s_ff.st == cmx_pkg::ST_MOVE && memRsp.ack && s_ff.req.op == cmx_pkg::MOP_WRITE)
    |=> (s_ff.cmd.idx == $past(s_ff.cmd.idx) - 16'h0001))
    else $error("count not decremented per written word");
endmodule

`default_nettype wire

// file: verif/cmx_mem_model.sv
`timescale 1ns/1ps
`default_nettype none

// ****************************************
// memory subsystem with maps, prompt or slow
// ****************************************
module cmx_mem_model #(
  parameter logic [15:0] BASE_OFF = 16'h0100 // base-relative offset, arbitrary
) (
  input wire logic clk_sys, // system clock
  input wire logic nrst, // async reset, low
  input wire logic slow, // add random wait states
  input wire cmx_pkg::cmx_memReq_s memReq, // request from engine
  output cmx_pkg::cmx_memRsp_s memRsp // answer
);
  logic [15:0] mem [logic [17:0]];
  logic [17:0] key;
  logic [15:0] rd;
  logic ack;
  logic flt;
  logic [2:0] waitCnt;

  // each map is its own space; low addresses are plain words here
  assign key = {memReq.map, memReq.addr};
  // a released bus shows the inverse of the last word, not a stale copy
  assign memRsp = {ack, ack ? rd : ~rd, ack & flt};

  // one request at a time, up to three wait states when slow
  always @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      ack <= 1'b0;
      rd <= 16'h0000;
      flt <= 1'b0;
      waitCnt <= 3'h0;
    end else begin
      ack <= 1'b0;
      if (memReq.valid && !ack) begin
        if (waitCnt != 3'h0) begin
          waitCnt <= waitCnt - 3'h1;
        end else begin
          ack <= 1'b1;
          flt <= 1'b0;
          waitCnt <= slow ? 3'($urandom_range(3, 0)) : 3'h0;
          case (memReq.op)
            cmx_pkg::MOP_WRITE: mem[key] = memReq.wdata;
            cmx_pkg::MOP_CHECK: begin
              rd <= memReq.addr + BASE_OFF;
              flt <= memReq.addr[14];
            end
            default: rd <= mem.exists(key) ? mem[key] : ~memReq.addr;
          endcase
        end
      end
    end
  end
endmodule

`default_nettype wire

// file: verif/tb_top.sv
`timescale 1ns/1ps
`default_nettype none

// ****************************************
// bench top: driver, result monitor, checks
// ****************************************
module tb_top;
  typedef struct packed {
    logic [1:0] kind; // 0 skip and pc, 1 restart (skip set: fault), 2 resume state, 3 full
    logic skip;
    logic [15:0] pc;
    logic [15:0] accA;
    logic [15:0] accB;
    logic [15:0] idx;
  } cmx_exp_s;
  localparam logic [15:0] OFF = 16'h0100;
  logic clk_sys;
  logic nrst;
  logic irqPend;
  logic slow;
  logic busy;
  cmx_pkg::cmx_cmd_s cmd;
  cmx_pkg::cmx_memReq_s memReq;
  cmx_pkg::cmx_memRsp_s memRsp;
  cmx_pkg::cmx_res_s res;
  cmx_pkg::cmx_res_s lastRes;
  cmx_exp_s expQ[$];
  cmx_exp_s monE;
  int checked;
  int n_mismatch;
  logic [15:0] vals[16];
  logic [15:0] cmpOp[4] = '{cmx_pkg::OP_CMP_FIRST_ACC_VIA_DATA_ONE,
    cmx_pkg::OP_CMP_SECOND_ACC_VIA_DATA_ONE, cmx_pkg::OP_CMP_FIRST_ACC_VIA_DATA_TWO,
    cmx_pkg::OP_CMP_SECOND_ACC_VIA_DATA_TWO};
  logic [15:0] mvOp[5] = '{16'h8bd7, 16'h8bd8, 16'h8bd9, 16'h8bda, 16'h8bdb};
  logic [1:0] srcMap[5] = '{2'h0, 2'h0, 2'h0, 2'h1, 2'h1};
  logic [1:0] dstMap[5] = '{2'h0, 2'h1, 2'h2, 2'h0, 2'h1};

  cmx_exec dut_u (.clk_sys(clk_sys), .nrst(nrst), .cmd(cmd), .irqPend(irqPend),
    .memReq(memReq), .memRsp(memRsp), .res(res), .busy(busy));
  cmx_mem_model #(.BASE_OFF(OFF)) mem_u (.clk_sys(clk_sys), .nrst(nrst), .slow(slow),
    .memReq(memReq), .memRsp(memRsp));

  // ****************************************
  // helpers
  // ****************************************
  task automatic chk(input logic [66:0] got, input logic [66:0] exp);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic poke(input logic [1:0] m, input logic [15:0] ad, input logic [15:0] v);
    mem_u.mem[{m, ad}] = v;
  endtask

  // start is a one-cycle pulse; the wait is bounded so a hang still ends the run
  task automatic run(input logic [15:0] op, pc, a, b, x, input logic code_data_separation_mode, input cmx_exp_s e);
    int n;
    @(negedge clk_sys);
    cmd = '{start: 1'b1, opcode: op, pc: pc, accA: a, accB: b, idx: x, cdsMode: code_data_separation_mode};
    expQ.push_back(e);
    @(negedge clk_sys);
    cmd.start = 1'b0;
    for (n = 0; n < 4000 && res.done !== 1'b1; n++) @(negedge clk_sys);
    if (n == 4000) chk(67'h1, 67'h0);
    @(negedge clk_sys);
  endtask

  task automatic test_done();
    $display("checks %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // ****************************************
  // clock, watchdog, result monitor
  // ****************************************
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  // about twenty thousand cycles, far above what the tests need
  initial begin
    #(200_000);
    n_mismatch++;
    test_done();
  end

  // done stands one cycle, so the falling edge inside it is a safe sample
  always @(negedge clk_sys) begin
    if (res.done === 1'b1) begin
      lastRes = res;
      if (expQ.size() == 0) begin
        chk(67'h1, 67'h0);
      end else begin
        monE = expQ.pop_front();
        case (monE.kind)
          2'h0: chk({res.skip, res.restart, res.fault, res.pc}, {monE.skip, 2'b00, monE.pc});
          2'h1: chk({res.restart, res.fault, res.pc}, {~monE.skip, monE.skip, monE.pc});
          2'h2: chk({res.restart, res.fault, res.accA - monE.accA, res.accB - monE.accB},
            {2'b10, monE.idx - res.idx, monE.idx - res.idx});
          default: chk({res.skip, res.restart, res.fault, res.pc, res.accA, res.accB, res.idx},
            {monE.skip, 2'b00, monE.pc, monE.accA, monE.accB, monE.idx});
        endcase
      end
    end
  end

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    int i;
    int k;
    int n;
    logic [15:0] op, a, b, sa, db, pc;
    logic [1:0] m;
    logic ne, code_data_separation_mode;
    cmd = '0;
    irqPend = 1'b0;
    slow = 1'b0;
    nrst = 1'b0;
    checked = 0;
    n_mismatch = 0;
    void'($urandom(32'h84b0fcef));
    repeat (10) @(negedge clk_sys);
    nrst = 1'b1;
    // every compare, equal then unequal; pointers 0 to 7 must reach memory
    for (i = 0; i < 8; i++) begin
      op = cmpOp[i % 4];
      m = (op[3:0] == 4'h6) ? 2'h1 : 2'h2;
      ne = (i >= 4);
      a = 16'($urandom);
      b = 16'($urandom);
      slow = i[0];
      pc = 16'h0200 + 16'(i * 4);
      poke(2'h0, pc + 16'h1, 16'(i));
      poke(m, 16'(i), (op[11] ? b : a) ^ {15'h0, ne});
      run(op, pc, a, b, 16'h0, 1'b0, '{2'h0, ne, pc + (ne ? 16'h3 : 16'h2), a, b, 16'h0});
    end
    $display("test compare done");
    // indirect chain of five levels, cut after three when an interrupt waits
    poke(2'h0, 16'h0301, 16'h8070);
    for (k = 0; k < 4; k++) poke(2'h0, 16'h0070 + 16'(k), 16'h8071 + 16'(k));
    poke(2'h0, 16'h0074, 16'h0060);
    poke(2'h1, 16'h0060, a);
    irqPend = 1'b1;
    run(cmpOp[0], 16'h0300, a, b, 16'h0, 1'b1, '{2'h1, 1'b0, 16'h0300, a, b, 16'h0});
    irqPend = 1'b0;
    run(cmpOp[0], 16'h0300, a, b, 16'h0, 1'b1, '{2'h0, 1'b0, 16'h0302, a, b, 16'h0});
    $display("test indirect done");
    // every word move, with and without separation mode, count zero first
    for (i = 0; i < 10; i++) begin
      code_data_separation_mode = (i >= 5);
      n = (i == 0) ? 0 : $urandom_range(12, 1);
      slow = i[1];
      a = 16'h1000 + 16'(i * 32);
      b = 16'h2000 + 16'(i * 32);
      sa = a + ((code_data_separation_mode && srcMap[i % 5] == 2'h0) ? OFF : 16'h0);
      db = b + ((code_data_separation_mode && dstMap[i % 5] == 2'h0) ? OFF : 16'h0);
      // addresses stay direct and never wrap
      for (k = 0; k < n; k++) begin
        vals[k] = 16'($urandom);
        poke(srcMap[i % 5], sa + 16'(k), vals[k]);
      end
      run(mvOp[i % 5], 16'h0400, a, b, 16'(n), code_data_separation_mode,
        '{2'h3, 1'b0, 16'h0401, sa + 16'(n), db + 16'(n), 16'h0});
      for (k = 0; k < n; k++) chk(mem_u.mem[{dstMap[i % 5], db + 16'(k)}], vals[k]);
    end
    $display("test move done");
    // interrupted move, then resumed from the returned registers
    for (k = 0; k < 12; k++) begin
      vals[k] = 16'($urandom);
      poke(2'h0, 16'h3000 + 16'(k), vals[k]);
    end
    // the interrupt arrives a few words into the block
    fork
      run(mvOp[0], 16'h0500, 16'h3000, 16'h3800, 16'h000c, 1'b0,
        '{2'h2, 1'b0, 16'h0500, 16'h3000, 16'h3800, 16'h000c});
      begin
        repeat (6) @(negedge clk_sys);
        irqPend = 1'b1;
      end
    join
    irqPend = 1'b0;
    run(mvOp[0], 16'h0500, lastRes.accA, lastRes.accB, lastRes.idx, 1'b0,
      '{2'h3, 1'b0, 16'h0501, 16'h300c, 16'h380c, 16'h0});
    for (k = 0; k < 12; k++) chk(mem_u.mem[{2'h0, 16'h3800 + 16'(k)}], vals[k]);
    $display("test resume done");
    // a foreign opcode and a failed source check end at once, pc kept
    run(16'h0000, 16'h0600, a, b, 16'h0000, 1'b0, '{2'h1, 1'b1, 16'h0600, a, b, 16'h0000});
    run(mvOp[0], 16'h0600, 16'h4000, 16'h2000, 16'h0004, 1'b1,
      '{2'h1, 1'b1, 16'h0600, a, b, 16'h0000});
    $display("test fault done");
    test_done();
  end
endmodule

`default_nettype wire
